// >>> hdl/jtag_nvm_engine.sv
// Vendor instruction engine behind the test access port, with its non-volatile store.
// Function
// - Bulk erase clears everything, second idle edge
// - Security program sets fuse, second idle edge
// - Set fuse blocks configuration readout
// - Discharge drops programming supply, reads allowed
// - Programming enable enters programming mode
// - Identification instruction shifts code onto output
// - Signature read loads and selects signature
// - Signature program stores register when enabled
// - Programming disable leaves programming mode
// - Test-Logic-Reset also cancels programming mode
// - Reset instruction pulses device reset, clears verify result
// - Done erase clears only done flag
// - Done program sets the done flag
// - Verify compares data with selected column
// - Configuration erase clears array, enabled only
// - Column address register selects later column
// - Data shift puts data register in path
// - Configuration program writes column, second idle edge
// - Sixteen vendor plus bypass, sample, extest
// - Column address register is four bits
// - Configuration data register is 56 bits
// - Sample and extest act as bypass
// - Identification register is 32 bits
module jtag_nvm_engine #(
  parameter logic [31:0] ID_CODE = 32'h0000_0001  // Identification value; arbitrary.
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        tck,                   // Test clock pin.
  input  wire logic        tms,                   // Mode select pin.
  input  wire logic        tdi,                   // Serial data in pin.
  output logic             tdo,                   // Serial data out.
  output logic             tdo_oe,                // High while shifting.
  output logic             prog_mode,             // Programming mode active.
  output logic             readout_protect_fuse,  // Stored security fuse.
  output logic             done_flag,             // Stored done flag.
  output logic             supply_high,           // Programming supply still charged.
  output logic             vpp_discharge,         // Pulse: supply discharge performed.
  output logic             device_reset,          // Pulse: device reset requested.
  output logic             verify_pass,           // Last verify matched.
  output logic [3:0]       cfg_column             // Selected configuration column.
);

  // Two-stage synchronisers for the pins and a delayed clock for edge finding.
  logic tck_s1, tck_s2, tck_d;
  logic tms_s1, tms_s2;
  logic tdi_s1, tdi_s2;

  // Pins enter the mclk domain; logic reads the second stage, and for the test clock also the third (tck_d).
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      // The clock stages reset to the pin's resting high level, so release shows no false rise.
      {tck_s1, tck_s2, tck_d} <= 3'h7;
      {tms_s1, tms_s2}        <= 2'h3;
      {tdi_s1, tdi_s2}        <= 2'h0;
    end else begin
      {tck_s1, tck_s2, tck_d} <= {tck, tck_s1, tck_s2};
      {tms_s1, tms_s2}        <= {tms, tms_s1};
      {tdi_s1, tdi_s2}        <= {tdi, tdi_s1};
    end
  end

  wire tck_rise = tck_s2 & ~tck_d;  // One-cycle pulse on each test clock rise.
  wire tck_fall = ~tck_s2 & tck_d;  // One-cycle pulse on each test clock fall.

  jtag_nvm_pkg::tap_state_t state;  // Port state.

  tap_state_tracker u_tap (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .tck_rise (tck_rise),
    .tms      (tms_s2),
    .state    (state)
  );

  // State decodes.
  wire in_tlr    = (state == jtag_nvm_pkg::ST_TLR);
  wire in_rti    = (state == jtag_nvm_pkg::ST_RTI);
  wire in_cap_dr = (state == jtag_nvm_pkg::ST_CAP_DR);
  wire in_sh_dr  = (state == jtag_nvm_pkg::ST_SH_DR);
  wire in_upd_dr = (state == jtag_nvm_pkg::ST_UPD_DR);
  wire in_cap_ir = (state == jtag_nvm_pkg::ST_CAP_IR);
  wire in_sh_ir  = (state == jtag_nvm_pkg::ST_SH_IR);
  wire in_upd_ir = (state == jtag_nvm_pkg::ST_UPD_IR);

  logic [7:0]  ir_sr;    // Instruction shift stage.
  logic [7:0]  ir;       // Active instruction.
  logic [1:0]  rti_count;  // Rising edges seen in the current idle stay.
  logic        bypass_reg;  // One-bit bypass path.
  logic [31:0] id_sr;      // Identification shift register.
  logic [31:0] user_signature_register;  // Signature shift register.
  logic [3:0]  addr_sr;    // Column address shift register.
  logic [55:0] data_sr;    // Configuration data shift register.
  logic [31:0] nv_signature;  // Stored signature.

  // Instruction decode; anything unlisted falls back to the bypass path.
  wire sel_id   = (ir == jtag_nvm_pkg::INS_IDCODE);
  wire sel_sig  = (ir == jtag_nvm_pkg::INS_SIG_READ) ||
                  (ir == jtag_nvm_pkg::INS_SIG_PROGRAM);
  wire sel_addr = (ir == jtag_nvm_pkg::INS_CFG_ADDRESS);
  wire sel_data = (ir == jtag_nvm_pkg::INS_CFG_SHIFT) ||
                  (ir == jtag_nvm_pkg::INS_CFG_VERIFY) ||
                  (ir == jtag_nvm_pkg::INS_CFG_PROGRAM);
  wire sel_bypass = ~(sel_id | sel_sig | sel_addr | sel_data);

  // Instruction taken at update, with the freshly shifted code.
  wire upd_ir = tck_rise & in_upd_ir;
  wire upd_dr = tck_rise & in_upd_dr;

  // Execution strobe: second rising edge inside Run-Test-Idle.
  wire rti_fire = tck_rise & in_rti & (rti_count == jtag_nvm_pkg::EXEC_EDGE - 2'h1);
  wire nv_ok    = rti_fire & prog_mode;

  // Non-volatile operation strobes, gated by programming mode; the verify strobe is not gated.
  wire do_bulk     = nv_ok & (ir == jtag_nvm_pkg::INS_BULK_ERASE);
  wire do_secure   = nv_ok & (ir == jtag_nvm_pkg::INS_PROG_SECURE);
  wire do_sig_prog = nv_ok & (ir == jtag_nvm_pkg::INS_SIG_PROGRAM);
  wire do_done_er  = nv_ok & (ir == jtag_nvm_pkg::INS_DONE_ERASE);
  wire do_done_pr  = nv_ok & (ir == jtag_nvm_pkg::INS_DONE_PROGRAM);
  wire do_cfg_er   = nv_ok & (ir == jtag_nvm_pkg::INS_CFG_ERASE);
  wire do_cfg_pr   = nv_ok & (ir == jtag_nvm_pkg::INS_CFG_PROGRAM);
  wire do_verify   = rti_fire & (ir == jtag_nvm_pkg::INS_CFG_VERIFY);
  wire nv_any = do_bulk | do_secure | do_sig_prog | do_done_er | do_done_pr | do_cfg_er | do_cfg_pr;

  // Configuration array, one stored column per generate entry.
  logic [55:0] cfg_view [16];
  genvar gi;
  generate
    for (gi = 0; gi < jtag_nvm_pkg::COLS; gi++) begin : g_col
      localparam logic [3:0] COL = 4'(gi);  // This entry's address.
      logic [55:0] col_q;                   // Stored column bits.
      // Erase clears the column; program only sets bits, as the cells do.
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          col_q <= jtag_nvm_pkg::DATA_ERASED;
        end else if (do_bulk || do_cfg_er) begin
          col_q <= jtag_nvm_pkg::DATA_ERASED;
        end else if (do_cfg_pr && (cfg_column == COL)) begin
          col_q <= col_q | data_sr;
        end
      end
      assign cfg_view[gi] = col_q;
    end
  endgenerate

  wire [55:0] sel_column = cfg_view[cfg_column];  // Column chosen by the address.
  wire [55:0] read_back  = readout_protect_fuse ? jtag_nvm_pkg::DATA_ERASED : sel_column;

  // Count rising edges spent in Run-Test-Idle; leaving it restarts the count.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rti_count <= 2'h0;
    end else if (tck_rise) begin
      rti_count <= (in_rti && rti_count != jtag_nvm_pkg::EXEC_EDGE) ? rti_count + 2'h1 :
                   (in_rti ? rti_count : 2'h0);
    end
  end

  // Instruction register: capture, shift and update.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ir_sr <= jtag_nvm_pkg::INS_IDCODE;
      ir    <= jtag_nvm_pkg::INS_IDCODE;
    end else if (tck_rise) begin
      if (in_tlr) begin
        ir <= jtag_nvm_pkg::INS_IDCODE;
      end else if (in_cap_ir) begin
        ir_sr <= jtag_nvm_pkg::INS_IDCODE;
      end else if (in_sh_ir) begin
        ir_sr <= {tdi_s2, ir_sr[7:1]};
      end else if (in_upd_ir) begin
        ir <= ir_sr;
      end
    end
  end

  // Programming mode: enable, disable and Test-Logic-Reset.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prog_mode <= 1'b0;
    end else if (in_tlr) begin
      prog_mode <= 1'b0;
    end else if (upd_ir && ir_sr == jtag_nvm_pkg::INS_PROG_ENABLE) begin
      prog_mode <= 1'b1;
    end else if (upd_ir && ir_sr == jtag_nvm_pkg::INS_PROG_DISABLE) begin
      prog_mode <= 1'b0;
    end
  end

  // Data registers: bypass and identification capture on Capture-DR, data only for the shift instruction; all shift on Shift-DR.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bypass_reg <= 1'b0;
      id_sr      <= ID_CODE;
      addr_sr    <= jtag_nvm_pkg::ADDR_RESET;
      data_sr    <= jtag_nvm_pkg::DATA_ERASED;
    end else if (tck_rise && in_cap_dr) begin
      bypass_reg <= 1'b0;
      id_sr      <= ID_CODE;
      if (ir == jtag_nvm_pkg::INS_CFG_SHIFT) begin
        data_sr <= read_back;
      end
    end else if (tck_rise && in_sh_dr) begin
      if (sel_bypass) bypass_reg <= tdi_s2;
      if (sel_id)     id_sr      <= {tdi_s2, id_sr[31:1]};
      if (sel_addr)   addr_sr    <= {tdi_s2, addr_sr[3:1]};
      if (sel_data)   data_sr    <= {tdi_s2, data_sr[55:1]};
    end
  end

  // Signature register: loaded from store when the read instruction lands.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      user_signature_register <= jtag_nvm_pkg::SIG_ERASED;
    end else if (upd_ir && ir_sr == jtag_nvm_pkg::INS_SIG_READ) begin
      user_signature_register <= nv_signature;
    end else if (tck_rise && in_sh_dr && sel_sig) begin
      user_signature_register <= {tdi_s2, user_signature_register[31:1]};
    end
  end

  // Column address takes effect at Update-DR.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfg_column <= jtag_nvm_pkg::ADDR_RESET;
    end else if (upd_dr && sel_addr) begin
      cfg_column <= addr_sr;
    end
  end

  // Stored signature, fuse and done flag.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      nv_signature         <= jtag_nvm_pkg::SIG_ERASED;
      readout_protect_fuse <= 1'b0;
      done_flag            <= 1'b0;
    end else if (do_bulk) begin
      nv_signature         <= jtag_nvm_pkg::SIG_ERASED;
      readout_protect_fuse <= 1'b0;
      done_flag            <= 1'b0;
    end else begin
      if (do_sig_prog) nv_signature <= nv_signature | user_signature_register;
      if (do_secure)   readout_protect_fuse <= 1'b1;
      if (do_done_er)  done_flag <= 1'b0;
      if (do_done_pr)  done_flag <= 1'b1;
    end
  end

  // Supply state, discharge pulse, reset pulse and verify result.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      supply_high   <= 1'b0;
      vpp_discharge <= 1'b0;
      device_reset  <= 1'b0;
      verify_pass   <= 1'b0;
    end else begin
      vpp_discharge <= upd_ir && ir_sr == jtag_nvm_pkg::INS_DISCHARGE;
      device_reset  <= upd_ir && ir_sr == jtag_nvm_pkg::INS_DEV_RESET;
      if (nv_any) begin
        supply_high <= 1'b1;
      end else if (upd_ir && ir_sr == jtag_nvm_pkg::INS_DISCHARGE) begin
        supply_high <= 1'b0;
      end
      if (upd_ir && ir_sr == jtag_nvm_pkg::INS_DEV_RESET) begin
        verify_pass <= 1'b0;
      end else if (do_verify) begin
        verify_pass <= !readout_protect_fuse && (data_sr == sel_column);
      end
    end
  end

  // Selected scan bit.
  wire dr_bit = sel_id   ? id_sr[0] :
                sel_sig  ? user_signature_register[0] :
                sel_addr ? addr_sr[0] :
                sel_data ? data_sr[0] : bypass_reg;

  // Serial output changes on the falling test clock edge.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= in_sh_ir ? ir_sr[0] : dr_bit;
      tdo_oe <= in_sh_ir | in_sh_dr;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_enable_mode: assert property (upd_ir && ir_sr == jtag_nvm_pkg::INS_PROG_ENABLE |=> prog_mode)
    else $error("Programming enable did not set programming mode");
  a_disable_mode: assert property (upd_ir && ir_sr == jtag_nvm_pkg::INS_PROG_DISABLE |=> !prog_mode)
    else $error("Programming disable did not clear programming mode");
  a_reset_cancels: assert property (in_tlr |=> !prog_mode)
    else $error("Programming mode survived Test-Logic-Reset");
  a_fire_edge: assert property (rti_fire |-> in_rti && $past(in_rti) && rti_count == 2'h1)
    else $error("Execution strobe not on second idle edge");
  a_fuse_program: assert property (do_secure |=> readout_protect_fuse ##1 readout_protect_fuse)
    else $error("Security program did not set the fuse");
  a_fuse_readout: assert property (readout_protect_fuse && tck_rise && in_cap_dr &&
                                   ir == jtag_nvm_pkg::INS_CFG_SHIFT |=> data_sr == 56'h0)
    else $error("Configuration data read out despite fuse");
  a_bulk_clears: assert property (do_bulk |=> !readout_protect_fuse && !done_flag && nv_signature == 32'h0)
    else $error("Bulk erase left stored content");
  a_no_mode_stable: assert property (rti_fire && !prog_mode |=>
                                     $stable(nv_signature) && $stable(readout_protect_fuse) && $stable(done_flag))
    else $error("Stored content changed outside programming mode");
  a_done_only: assert property (do_done_er |=> !done_flag && $stable(nv_signature) && $stable(readout_protect_fuse))
    else $error("Done erase touched other content");
  a_discharge: assert property (upd_ir && ir_sr == jtag_nvm_pkg::INS_DISCHARGE |=> vpp_discharge && !supply_high)
    else $error("Discharge did not drop the supply");
  a_id_shift_out: assert property (tck_fall && in_sh_dr && sel_id |=> tdo == $past(id_sr[0]) && tdo_oe)
    else $error("Identification bit not driven on serial output");

  c_cfg_program: cover property (do_cfg_pr);
  c_verify_pass: cover property (do_verify ##1 verify_pass);
  c_sig_read:    cover property (upd_ir && ir_sr == jtag_nvm_pkg::INS_SIG_READ);
  c_fuse_set:    cover property (do_secure);

endmodule : jtag_nvm_engine

// >>> hdl/jtag_nvm_pkg.sv
// Shared constants and types for the test-port instruction engine.
package jtag_nvm_pkg;

  // Register widths.
  localparam int IR_W   = 8;   // Instruction register length.
  localparam int ID_W   = 32;  // Identification shift register length.
  localparam int SIG_W  = 32;  // User signature register length.
  localparam int ADDR_W = 4;   // Configuration column address length.
  localparam int DATA_W = 56;  // Configuration data shift register length.
  localparam int COLS   = 16;  // Columns reachable by the column address.

  // Instruction codes.
  localparam logic [7:0] INS_EXTEST       = 8'h00;
  localparam logic [7:0] INS_BULK_ERASE   = 8'h03;
  localparam logic [7:0] INS_PROG_SECURE  = 8'h09;
  localparam logic [7:0] INS_DISCHARGE    = 8'h14;
  localparam logic [7:0] INS_PROG_ENABLE  = 8'h15;
  localparam logic [7:0] INS_IDCODE       = 8'h16;
  localparam logic [7:0] INS_SIG_READ     = 8'h17;
  localparam logic [7:0] INS_SIG_PROGRAM  = 8'h1a;
  localparam logic [7:0] INS_SAMPLE       = 8'h1c;
  localparam logic [7:0] INS_PROG_DISABLE = 8'h1e;
  localparam logic [7:0] INS_DEV_RESET    = 8'h22;
  localparam logic [7:0] INS_DONE_ERASE   = 8'h24;
  localparam logic [7:0] INS_CFG_VERIFY   = 8'h28;
  localparam logic [7:0] INS_CFG_ERASE    = 8'h29;
  localparam logic [7:0] INS_CFG_ADDRESS  = 8'h2b;
  localparam logic [7:0] INS_CFG_SHIFT    = 8'h2d;
  localparam logic [7:0] INS_CFG_PROGRAM  = 8'h2e;
  localparam logic [7:0] INS_DONE_PROGRAM = 8'h2f;
  localparam logic [7:0] INS_BYPASS       = 8'hff;

  // Run-Test-Idle edge on which erase, program and verify act.
  localparam logic [1:0] EXEC_EDGE = 2'h2;

  // Reset and erased values.
  localparam logic [DATA_W-1:0] DATA_ERASED = 56'h0;
  localparam logic [SIG_W-1:0]  SIG_ERASED  = 32'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 4'h0;

  // Test access port states, one-hot.
  typedef enum logic [15:0] {
    ST_TLR    = 16'h0001,
    ST_RTI    = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;

endpackage : jtag_nvm_pkg

// >>> hdl/tap_state_tracker.sv
// Test access port state sequencer, advanced on each sampled clock rising edge.
module tap_state_tracker (
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic                    tck_rise,  // One-cycle pulse per test clock rising edge.
  input  wire logic                    tms,       // Synchronised mode select.
  output jtag_nvm_pkg::tap_state_t     state
);

  jtag_nvm_pkg::tap_state_t next_state;  // State after the coming edge.

  // Next-state table; mode select steers every transition.
  always_comb begin
    unique case (state)
      jtag_nvm_pkg::ST_TLR:    next_state = tms ? jtag_nvm_pkg::ST_TLR    : jtag_nvm_pkg::ST_RTI;
      jtag_nvm_pkg::ST_RTI:    next_state = tms ? jtag_nvm_pkg::ST_SEL_DR : jtag_nvm_pkg::ST_RTI;
      jtag_nvm_pkg::ST_SEL_DR: next_state = tms ? jtag_nvm_pkg::ST_SEL_IR : jtag_nvm_pkg::ST_CAP_DR;
      jtag_nvm_pkg::ST_CAP_DR: next_state = tms ? jtag_nvm_pkg::ST_EX1_DR : jtag_nvm_pkg::ST_SH_DR;
      jtag_nvm_pkg::ST_SH_DR:  next_state = tms ? jtag_nvm_pkg::ST_EX1_DR : jtag_nvm_pkg::ST_SH_DR;
      jtag_nvm_pkg::ST_EX1_DR: next_state = tms ? jtag_nvm_pkg::ST_UPD_DR : jtag_nvm_pkg::ST_PA_DR;
      jtag_nvm_pkg::ST_PA_DR:  next_state = tms ? jtag_nvm_pkg::ST_EX2_DR : jtag_nvm_pkg::ST_PA_DR;
      jtag_nvm_pkg::ST_EX2_DR: next_state = tms ? jtag_nvm_pkg::ST_UPD_DR : jtag_nvm_pkg::ST_SH_DR;
      jtag_nvm_pkg::ST_UPD_DR: next_state = tms ? jtag_nvm_pkg::ST_SEL_DR : jtag_nvm_pkg::ST_RTI;
      jtag_nvm_pkg::ST_SEL_IR: next_state = tms ? jtag_nvm_pkg::ST_TLR    : jtag_nvm_pkg::ST_CAP_IR;
      jtag_nvm_pkg::ST_CAP_IR: next_state = tms ? jtag_nvm_pkg::ST_EX1_IR : jtag_nvm_pkg::ST_SH_IR;
      jtag_nvm_pkg::ST_SH_IR:  next_state = tms ? jtag_nvm_pkg::ST_EX1_IR : jtag_nvm_pkg::ST_SH_IR;
      jtag_nvm_pkg::ST_EX1_IR: next_state = tms ? jtag_nvm_pkg::ST_UPD_IR : jtag_nvm_pkg::ST_PA_IR;
      jtag_nvm_pkg::ST_PA_IR:  next_state = tms ? jtag_nvm_pkg::ST_EX2_IR : jtag_nvm_pkg::ST_PA_IR;
      jtag_nvm_pkg::ST_EX2_IR: next_state = tms ? jtag_nvm_pkg::ST_UPD_IR : jtag_nvm_pkg::ST_SH_IR;
      jtag_nvm_pkg::ST_UPD_IR: next_state = tms ? jtag_nvm_pkg::ST_SEL_DR : jtag_nvm_pkg::ST_RTI;
      default:                 next_state = jtag_nvm_pkg::ST_TLR;
    endcase
  end

  // The state only moves on a test clock rising edge.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= jtag_nvm_pkg::ST_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

endmodule : tap_state_tracker

// >>> tb/jtag_host.sv
// Behavioural test-port programmer that drives the clock, mode and data pins.
module jtag_host (
  input  wire logic mclk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  timeunit 1ns;
  timeprecision 1ps;

  // The test clock rests high between frames and only moves inside a task.
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock period of 160 ns; pins change at the fall, tdo is taken just before the rise.
  task automatic bit_io(input logic m, input logic d, output logic o);
    @(negedge mclk);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (10) @(negedge mclk);
    o = tdo;
    tck = 1'b1;
    repeat (9) @(negedge mclk);
  endtask : bit_io

  // A state step; the unused data pin toggles so no stale value survives.
  task automatic move(input logic m);
    logic o;
    bit_io(m, ~tdi, o);
  endtask : move

  // Shifts n bits from the least significant end, then walks through Update into idle.
  task automatic scan(input logic [63:0] din, input int n, output logic [63:0] dout);
    logic o;
    dout = 64'h0;
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], o);
      dout[i] = o;
    end
    move(1'b1);
    move(1'b0);
  endtask : scan

  // Loads an instruction from idle, ending back in idle.
  task automatic ir(input logic [7:0] code);
    logic [63:0] d;
    move(1'b1);
    move(1'b1);
    move(1'b0);
    move(1'b0);
    scan({56'h0, code}, 8, d);
  endtask : ir

  // Scans the selected data register from idle, ending back in idle.
  task automatic dr(input logic [63:0] din, input int n, output logic [63:0] dout);
    move(1'b1);
    move(1'b0);
    move(1'b0);
    scan(din, n, dout);
  endtask : dr

  // Stays in idle for n test clock rises.
  task automatic idle(input int n);
    repeat (n) move(1'b0);
  endtask : idle

  // Five high mode bits reach Test-Logic-Reset, then one low bit enters idle.
  task automatic reset_port();
    repeat (5) move(1'b1);
    move(1'b0);
  endtask : reset_port
endmodule : jtag_host

// >>> tb/tb.sv
// Self-checking bench for the test-port instruction engine with a behavioural programmer.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID_VAL = 32'h5a3c_0f01;  // Identification value; arbitrary.
  logic        mclk, reset_n, tck, tms, tdi, tdo, tdo_oe, prog_mode;  // Clock, reset and pins.
  logic        readout_protect_fuse, done_flag, supply_high, vpp_discharge, device_reset, verify_pass;
  logic [3:0]  cfg_column;  // Selected column from the design.
  logic [3:0]  col;         // Random target column.
  logic [55:0] data;        // Random column contents.
  logic [31:0] sig;         // Random signature.
  logic [63:0] d, tmp;      // Scan results and scratch.
  logic [1:0]  b;           // Bypass stimulus.
  logic        disc_seen, rst_seen;  // Sticky copies of the one-cycle pulses.
  logic        oe_seen;              // Sticky copy of the output enable.
  int          seed, errors, compares;
  logic [7:0]  byp [4] = '{jtag_nvm_pkg::INS_EXTEST, jtag_nvm_pkg::INS_SAMPLE, jtag_nvm_pkg::INS_BYPASS, 8'h3f};

  jtag_nvm_engine #(.ID_CODE(ID_VAL)) jtag_nvm_engine_i (.mclk(mclk), .reset_n(reset_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .prog_mode(prog_mode), .readout_protect_fuse(readout_protect_fuse),
    .done_flag(done_flag), .supply_high(supply_high), .vpp_discharge(vpp_discharge),
    .device_reset(device_reset), .verify_pass(verify_pass), .cfg_column(cfg_column));
  jtag_host jtag_host_i (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

  // The 125 MHz system clock.
  always #4 mclk = ~mclk;

  // Pulses are too short for the scan tasks to see, so they are latched here.
  always @(posedge mclk) begin
    if (vpp_discharge === 1'b1) disc_seen <= 1'b1;
    if (device_reset === 1'b1) rst_seen <= 1'b1;
    if (tdo_oe === 1'b1) oe_seen <= 1'b1;
  end

  // A bypass scan returns the captured zero first, then the first bit sent in.
  function automatic logic [63:0] byp_exp(input logic [1:0] v);
    return {62'h0, v[0], 1'b0};
  endfunction : byp_exp

  // Compares wide scan results.
  task automatic check_word(input logic [63:0] got, input logic [63:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check_word

  // Compares single status flags.
  task automatic check_flag(input logic got, input logic exp, input string msg);
    check_word({63'h0, got}, {63'h0, exp}, msg);
  endtask : check_flag

  // Selects the data instruction, reads the stored column out and leaves the test data in the shift register.
  task automatic load_cfg();
    jtag_host_i.ir(jtag_nvm_pkg::INS_CFG_SHIFT);
    jtag_host_i.dr({8'h0, data}, 56, d);
  endtask : load_cfg

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Cuts a hang short.
  initial begin
    #600000;
    errors++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    seed = 27;
    disc_seen = 1'b0;
    rst_seen = 1'b0;
    oe_seen = 1'b0;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    jtag_host_i.reset_port();
    jtag_host_i.dr(64'h0, 32, d);
    check_word(d, {32'h0, ID_VAL}, "identification");
    check_flag(oe_seen, 1'b1, "output enable in shift");
    check_flag(tdo_oe, 1'b0, "output enable in idle");
    foreach (byp[k]) begin
      b = 2'($random(seed));
      jtag_host_i.ir(byp[k]);
      jtag_host_i.dr({62'h0, b}, 2, d);
      check_word(d, byp_exp(b), "bypass");
    end
    tmp = {$random(seed), $random(seed)};
    data = tmp[55:0];
    col = tmp[59:56];
    sig = $random(seed);
    jtag_host_i.ir(jtag_nvm_pkg::INS_CFG_ADDRESS);
    jtag_host_i.dr({60'h0, col}, 4, d);
    check_word({60'h0, cfg_column}, {60'h0, col}, "column select");
    load_cfg();
    jtag_host_i.ir(jtag_nvm_pkg::INS_CFG_PROGRAM);
    jtag_host_i.idle(3);
    check_flag(supply_high, 1'b0, "program without enable");
    load_cfg();
    check_word(d, 64'h0, "column untouched");
    jtag_host_i.ir(jtag_nvm_pkg::INS_PROG_ENABLE);
    check_flag(prog_mode, 1'b1, "enable");
    jtag_host_i.ir(jtag_nvm_pkg::INS_CFG_ERASE);
    jtag_host_i.idle(2);
    check_flag(supply_high, 1'b1, "erase ran");
    load_cfg();
    jtag_host_i.ir(jtag_nvm_pkg::INS_CFG_PROGRAM);
    jtag_host_i.idle(2);
    load_cfg();
    check_word(d, {8'h0, data}, "column program");
    jtag_host_i.ir(jtag_nvm_pkg::INS_CFG_VERIFY);
    jtag_host_i.idle(2);
    check_flag(verify_pass, 1'b1, "verify match");
    jtag_host_i.ir(jtag_nvm_pkg::INS_DONE_PROGRAM);
    jtag_host_i.idle(1);
    check_flag(done_flag, 1'b0, "first idle edge");
    jtag_host_i.idle(1);
    check_flag(done_flag, 1'b1, "second idle edge");
    jtag_host_i.ir(jtag_nvm_pkg::INS_DONE_ERASE);
    jtag_host_i.idle(2);
    check_flag(done_flag, 1'b0, "done erase");
    load_cfg();
    check_word(d, {8'h0, data}, "column kept");
    jtag_host_i.ir(jtag_nvm_pkg::INS_SIG_READ);
    jtag_host_i.dr({32'h0, sig}, 32, d);
    check_word(d, 64'h0, "blank signature");
    jtag_host_i.ir(jtag_nvm_pkg::INS_SIG_PROGRAM);
    jtag_host_i.idle(2);
    jtag_host_i.ir(jtag_nvm_pkg::INS_SIG_READ);
    jtag_host_i.dr(64'h0, 32, d);
    check_word(d, {32'h0, sig}, "signature");
    jtag_host_i.ir(jtag_nvm_pkg::INS_DISCHARGE);
    check_flag(supply_high, 1'b0, "discharge");
    check_flag(disc_seen, 1'b1, "discharge pulse");
    jtag_host_i.ir(jtag_nvm_pkg::INS_DEV_RESET);
    check_flag(verify_pass, 1'b0, "reset clears verify");
    check_flag(rst_seen, 1'b1, "reset pulse");
    jtag_host_i.ir(jtag_nvm_pkg::INS_CFG_VERIFY);
    jtag_host_i.idle(2);
    check_flag(verify_pass, 1'b1, "verify before fuse");
    jtag_host_i.ir(jtag_nvm_pkg::INS_PROG_SECURE);
    jtag_host_i.idle(2);
    check_flag(readout_protect_fuse, 1'b1, "fuse");
    load_cfg();
    check_word(d, 64'h0, "protected readout");
    jtag_host_i.ir(jtag_nvm_pkg::INS_CFG_VERIFY);
    jtag_host_i.idle(2);
    check_flag(verify_pass, 1'b0, "protected verify");
    jtag_host_i.ir(jtag_nvm_pkg::INS_BULK_ERASE);
    jtag_host_i.idle(2);
    check_flag(readout_protect_fuse, 1'b0, "bulk erase fuse");
    jtag_host_i.ir(jtag_nvm_pkg::INS_SIG_READ);
    jtag_host_i.dr(64'h0, 32, d);
    check_word(d, 64'h0, "bulk erase signature");
    jtag_host_i.ir(jtag_nvm_pkg::INS_DONE_PROGRAM);
    jtag_host_i.idle(2);
    jtag_host_i.ir(jtag_nvm_pkg::INS_PROG_DISABLE);
    check_flag(prog_mode, 1'b0, "disable");
    jtag_host_i.ir(jtag_nvm_pkg::INS_DONE_ERASE);
    jtag_host_i.idle(2);
    check_flag(done_flag, 1'b1, "done erase refused");
    jtag_host_i.ir(jtag_nvm_pkg::INS_PROG_ENABLE);
    jtag_host_i.reset_port();
    check_flag(prog_mode, 1'b0, "logic reset");
    wrap_up();
  end
endmodule : tb
